//--- rtl/hasd_consts.svh
// constants of the host address space decoder: offsets, fields, resets, ranges
// assumes inclusion by bare name from the package and the design modules
`ifndef HASD_CONSTS_SVH
`define HASD_CONSTS_SVH

// register byte offsets on the axi4-lite port
`define HASD_OFF_TOM        12'h000
`define HASD_OFF_HOLE       12'h004
`define HASD_OFF_SMM        12'h008
`define HASD_OFF_SHADOW     12'h00C
`define HASD_OFF_CFGADDR    12'h010
`define HASD_OFF_STATUS     12'h014

// field positions
`define HASD_HOLE_EN_BIT    0
`define HASD_SMM_EN_BIT     0
`define HASD_SMM_INIT_BIT   1
`define HASD_CFG_EN_BIT     31
`define HASD_TOM_DENS_BIT   31

// reset values
`define HASD_TOM_RST        32'h0100_0000
`define HASD_HOLE_RST       32'h0000_0000
`define HASD_SMM_RST        32'h0000_0000
`define HASD_SHADOW_RST     32'h0000_0000
`define HASD_CFGADDR_RST    32'h0000_0000

// memory ranges (36-bit host addresses)
`define HASD_MB1            36'h0_0010_0000
`define HASD_GB4            36'h1_0000_0000
`define HASD_APIC_LO        36'h0_FEC0_0000
`define HASD_APIC_HI        36'h0_FEC1_0000
`define HASD_HBIOS_LO       36'h0_FFE0_0000
`define HASD_SMM_LO         36'h0_000A_0000
`define HASD_SMM_HI         36'h0_000C_0000
`define HASD_HOLE_LO        36'h0_0008_0000
`define HASD_HOLE_HI        36'h0_000A_0000
`define HASD_SHD_LO         36'h0_000C_0000
`define HASD_SHD_HI         36'h0_0010_0000
`define HASD_TOM_MAX16      36'h0_1000_0000
`define HASD_TOM_MAX64      36'h0_4000_0000

// i/o ports
`define HASD_IO_CFGADDR     16'h0CF8
`define HASD_IO_CFGDATA     16'h0CFC

// host bus clock limit and register port clock
`define HASD_HOST_MHZ_MAX   66
`define HASD_CLK_MHZ        100

`endif

//--- rtl/hasd_pkg.sv
// types of the host address space decoder
// assumes the constants header sits beside it
package hasd_pkg;
  `include "hasd_consts.svh"

  // where a cycle goes
  typedef enum logic [4:0] {
    HASD_TGT_NONE   = 5'b00001,
    HASD_TGT_DRAM   = 5'b00010,
    HASD_TGT_PCI    = 5'b00100,
    HASD_TGT_INTERN = 5'b01000,
    HASD_TGT_ABORT  = 5'b10000
  } hasd_tgt_type;

  // one host or pci request
  typedef struct packed {
    logic        valid;
    logic        is_io;
    logic        write;
    logic        smm;
    logic        from_pci;
    logic [35:0] addr;
  } hasd_req_type;

  // decode result
  typedef struct packed {
    logic         valid;
    hasd_tgt_type tgt;
    logic         zero_read;
    logic         cfg_data;
  } hasd_dec_type;
endpackage

//--- rtl/hasd_route.sv
// combinational address router: one request in, one target out
// assumes settled control values from the register file
`timescale 1ns/1ns
`include "hasd_consts.svh"
module hasd_route
  import hasd_pkg::*;
#(
  parameter int SHD_BLOCKS = 16
) (
  input  wire hasd_req_type          req,
  input  wire logic [35:0]           main_memory_top_boundary,
  input  wire logic                  hole_en,
  input  wire logic                  smm_en,
  input  wire logic [SHD_BLOCKS-1:0] shd_rd,
  input  wire logic [SHD_BLOCKS-1:0] shd_wr,
  output hasd_dec_type               dec
);
  logic [35:0] a;
  logic [3:0]  blk;
  logic        in_shd;
  logic        shd_hit;

  // shadow block index: 16 kb blocks from c0000 to fffff
  assign a      = req.addr;
  assign in_shd = (a >= `HASD_SHD_LO) && (a < `HASD_SHD_HI);
  assign blk    = a[17:14];
  assign shd_hit = req.write ? shd_wr[blk] : shd_rd[blk];

  // priority decode: overlays first, then default map
  always_comb begin
    dec.valid     = req.valid;
    dec.tgt       = HASD_TGT_NONE;
    dec.zero_read = 1'b0;
    dec.cfg_data  = 1'b0;
    if (req.is_io) begin
      if (req.from_pci) begin
        dec.tgt = HASD_TGT_NONE;
      end else if (a[15:0] == `HASD_IO_CFGADDR) begin
        dec.tgt = HASD_TGT_INTERN;
      end else if (a[15:0] == `HASD_IO_CFGDATA) begin
        dec.tgt      = HASD_TGT_INTERN;
        dec.cfg_data = 1'b1;
      end else begin
        dec.tgt = HASD_TGT_PCI;
      end
    end else if (req.from_pci) begin
      // pci masters reach dram only in plain main memory
      if ((a >= `HASD_SMM_LO) && (a < `HASD_SMM_HI)) begin
        dec.tgt = HASD_TGT_NONE;
      end else if (in_shd) begin
        dec.tgt = HASD_TGT_NONE;
      end else if ((a >= `HASD_HOLE_LO) && (a < `HASD_HOLE_HI) && hole_en) begin
        dec.tgt = HASD_TGT_NONE;
      end else if (a < main_memory_top_boundary) begin
        dec.tgt = HASD_TGT_DRAM;
      end else begin
        dec.tgt = HASD_TGT_NONE;
      end
    end else if (a >= `HASD_GB4) begin
      dec.tgt       = HASD_TGT_ABORT;
      dec.zero_read = ~req.write;
    end else if ((a >= `HASD_SMM_LO) && (a < `HASD_SMM_HI)) begin
      dec.tgt = (smm_en && req.smm) ? HASD_TGT_DRAM : HASD_TGT_PCI;
    end else if (in_shd) begin
      dec.tgt = shd_hit ? HASD_TGT_DRAM : HASD_TGT_PCI;
    end else if ((a >= `HASD_HOLE_LO) && (a < `HASD_HOLE_HI) && hole_en) begin
      dec.tgt = HASD_TGT_PCI;
    end else if ((a >= `HASD_APIC_LO) && (a < `HASD_APIC_HI)) begin
      dec.tgt = HASD_TGT_PCI;
    end else if ((a >= `HASD_APIC_HI) && (a < `HASD_HBIOS_LO)) begin
      dec.tgt = HASD_TGT_PCI;
    end else if (a >= `HASD_HBIOS_LO) begin
      dec.tgt = HASD_TGT_PCI;
    end else if (a < main_memory_top_boundary) begin
      dec.tgt = HASD_TGT_DRAM;
    end else begin
      dec.tgt = HASD_TGT_PCI;
    end
  end
endmodule

//--- rtl/hasd_top.sv
// host address space decoder: axi4-lite control registers plus registered routing
// assumes one 100 mhz clock, synchronous active-low reset, one request per cycle
// assumes word-aligned register offsets; any other address answers slverr
//
// Behaviour
// - 1 MB to top of memory goes to dram
// - top of memory to 4 GB goes to pci
// - top boundary capped 256 MB or 1 GB
// - apic window at FEC00000h forwarded to pci
// - apic end to high bios always pci
// - top 2 MB high bios goes to pci
// - smm range to pci when smm disabled
// - smm cycles to dram when smm enabled and initialised
// - pci masters never reach smm dram
// - shadow reads and writes routed separately
// - shadowed blocks ignored for pci masters
// - host i/o goes to pci except internals
// - claim config ports 0CF8h and 0CFCh
// - host bus up to 66 MHz, two processors
// - above 4 GB terminated, reads return zero
`timescale 1ns/1ns
`include "hasd_consts.svh"
module hasd_top
  import hasd_pkg::*;
#(
  parameter int SHD_BLOCKS = 16
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite slave
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // requests from host bus or pci masters
  input  wire hasd_req_type host_req,
  input  wire logic [31:0] host_wdata,
  // routing result, one cycle after the request
  output hasd_dec_type     route,
  output logic [31:0]      cfg_addr_out,
  output logic [31:0]      host_rdata
);
  // stored control
  logic [31:0] tom_r, tom_nxt;
  logic [31:0] hole_r, hole_nxt;
  logic [31:0] smm_r, smm_nxt;
  logic [31:0] shd_r, shd_nxt;
  logic [31:0] cfga_r, cfga_nxt;
  logic [31:0] seen_r, seen_nxt;
  // bus state
  logic        aw_hold_r, aw_hold_nxt;
  logic [11:0] aw_addr_r, aw_addr_nxt;
  logic        w_hold_r, w_hold_nxt;
  logic [31:0] w_data_r, w_data_nxt;
  logic [3:0]  w_strb_r, w_strb_nxt;
  logic        bvalid_r, bvalid_nxt;
  logic [1:0]  bresp_r, bresp_nxt;
  logic        rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0]  rresp_r, rresp_nxt;
  logic        awready_r, awready_nxt;
  logic        wready_r, wready_nxt;
  logic        arready_r, arready_nxt;
  // decode path
  hasd_dec_type dec_c;
  hasd_dec_type route_r, route_nxt;
  logic [31:0]  hrd_r, hrd_nxt;
  logic [35:0]  tom_eff;
  logic [35:0]  tom_cap;
  logic [35:0]  tom_raw;
  logic         do_write;
  logic         aw_mapped;

  // cap boundary by dram density: bit 31 set means 64 mb parts
  assign tom_raw = {5'h00, tom_r[30:20], 20'h0_0000};
  assign tom_cap = tom_r[`HASD_TOM_DENS_BIT] ? `HASD_TOM_MAX64 : `HASD_TOM_MAX16;
  assign tom_eff = (tom_raw > tom_cap) ? tom_cap : tom_raw;

  hasd_route #(
    .SHD_BLOCKS (SHD_BLOCKS)
  ) u_route (
    .req     (host_req),
    .main_memory_top_boundary     (tom_eff),
    .hole_en (hole_r[`HASD_HOLE_EN_BIT]),
    .smm_en  (smm_r[`HASD_SMM_EN_BIT] & smm_r[`HASD_SMM_INIT_BIT]),
    .shd_rd  (shd_r[SHD_BLOCKS-1:0]),
    .shd_wr  (shd_r[2*SHD_BLOCKS-1:SHD_BLOCKS]),
    .dec     (dec_c)
  );

  // only aligned, writable offsets accept data; status is read-only
  assign aw_mapped = (aw_addr_r[1:0] == 2'h0) && (aw_addr_r <= `HASD_OFF_CFGADDR);

  // write channel capture and response
  always_comb begin
    aw_hold_nxt = aw_hold_r;
    aw_addr_nxt = aw_addr_r;
    w_hold_nxt  = w_hold_r;
    w_data_nxt  = w_data_r;
    w_strb_nxt  = w_strb_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    do_write    = 1'b0;
    if (s_axi_awvalid && !aw_hold_r && !bvalid_r) begin
      aw_hold_nxt = 1'b1;
      aw_addr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_hold_r && !bvalid_r) begin
      w_hold_nxt = 1'b1;
      w_data_nxt = s_axi_wdata;
      w_strb_nxt = s_axi_wstrb;
    end
    if (aw_hold_r && w_hold_r && !bvalid_r) begin
      do_write    = 1'b1;
      aw_hold_nxt = 1'b0;
      w_hold_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = aw_mapped ? 2'h0 : 2'h2;
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    // readies follow the hold state of the coming cycle
    awready_nxt = ~aw_hold_nxt & ~bvalid_nxt;
    wready_nxt  = ~w_hold_nxt & ~bvalid_nxt;
  end

  // merge bytes into one register
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        m[8*i +: 8] = d[8*i +: 8];
      end
    end
    return m;
  endfunction

  // register file next values, host config port writes included
  always_comb begin
    tom_nxt  = tom_r;
    hole_nxt = hole_r;
    smm_nxt  = smm_r;
    shd_nxt  = shd_r;
    cfga_nxt = cfga_r;
    seen_nxt = seen_r;
    if (do_write) begin
      case (aw_addr_r)
        `HASD_OFF_TOM:     tom_nxt  = merge(tom_r, w_data_r, w_strb_r);
        `HASD_OFF_HOLE:    hole_nxt = merge(hole_r, w_data_r, w_strb_r);
        `HASD_OFF_SMM:     smm_nxt  = merge(smm_r, w_data_r, w_strb_r);
        `HASD_OFF_SHADOW:  shd_nxt  = merge(shd_r, w_data_r, w_strb_r);
        `HASD_OFF_CFGADDR: cfga_nxt = merge(cfga_r, w_data_r, w_strb_r);
        default: ;
      endcase
    end
    // host write to the config address port wins over software
    if (host_req.valid && host_req.write && dec_c.tgt == HASD_TGT_INTERN && !dec_c.cfg_data) begin
      cfga_nxt = host_wdata;
    end
    // sticky count of abort terminations in low half
    if (dec_c.valid && dec_c.tgt == HASD_TGT_ABORT) begin
      seen_nxt[15:0] = seen_r[15:0] + 16'h0001;
    end
    seen_nxt[31:16] = {11'h000, route_r.tgt};
  end

  // read channel
  always_comb begin
    rvalid_nxt = rvalid_r;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    if (s_axi_arvalid && !rvalid_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = 2'h0;
      case (s_axi_araddr)
        `HASD_OFF_TOM:     rdata_nxt = tom_r;
        `HASD_OFF_HOLE:    rdata_nxt = hole_r;
        `HASD_OFF_SMM:     rdata_nxt = smm_r;
        `HASD_OFF_SHADOW:  rdata_nxt = shd_r;
        `HASD_OFF_CFGADDR: rdata_nxt = cfga_r;
        `HASD_OFF_STATUS:  rdata_nxt = seen_r;
        default: begin
          rdata_nxt = 32'h0000_0000;
          rresp_nxt = 2'h2;
        end
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    // no new address while an answer waits
    arready_nxt = ~rvalid_nxt;
  end

  // registered route and host read data
  always_comb begin
    route_nxt = dec_c;
    hrd_nxt   = 32'h0000_0000;
    if (dec_c.valid && dec_c.tgt == HASD_TGT_INTERN && !dec_c.cfg_data) begin
      hrd_nxt = cfga_r;
    end else if (dec_c.zero_read) begin
      hrd_nxt = 32'h0000_0000;
    end
  end

  // write channel registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      aw_addr_r <= 12'h000;
      w_hold_r  <= 1'b0;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= 2'h0;
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
    end else begin
      aw_hold_r <= aw_hold_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_hold_r  <= w_hold_nxt;
      w_data_r  <= w_data_nxt;
      w_strb_r  <= w_strb_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      awready_r <= awready_nxt;
      wready_r  <= wready_nxt;
    end
  end

  // control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tom_r     <= `HASD_TOM_RST;
      hole_r    <= `HASD_HOLE_RST;
      smm_r     <= `HASD_SMM_RST;
      shd_r     <= `HASD_SHADOW_RST;
      cfga_r    <= `HASD_CFGADDR_RST;
      seen_r    <= 32'h0000_0000;
    end else begin
      tom_r     <= tom_nxt;
      hole_r    <= hole_nxt;
      smm_r     <= smm_nxt;
      shd_r     <= shd_nxt;
      cfga_r    <= cfga_nxt;
      seen_r    <= seen_nxt;
    end
  end

  // read channel registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= 2'h0;
      arready_r <= 1'b1;
    end else begin
      rvalid_r  <= rvalid_nxt;
      rdata_r   <= rdata_nxt;
      rresp_r   <= rresp_nxt;
      arready_r <= arready_nxt;
    end
  end

  // decode result registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      route_r   <= '{valid: 1'b0, tgt: HASD_TGT_NONE, zero_read: 1'b0, cfg_data: 1'b0};
      hrd_r     <= 32'h0000_0000;
    end else begin
      route_r   <= route_nxt;
      hrd_r     <= hrd_nxt;
    end
  end

  // outputs straight from flops
  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign route         = route_r;
  assign cfg_addr_out  = cfga_r;
  assign host_rdata    = hrd_r;
endmodule

//--- test/hasd_top_monitor.sv
// checker of the decoder: routing results, config port load, read answer timing
// assumes binding onto hasd_top with one clock and synchronous active-low reset
`timescale 1ns/1ns
`include "hasd_consts.svh"
module hasd_top_monitor
  import hasd_pkg::*;
(
  input wire logic         aclk,
  input wire logic         aresetn,
  input wire logic         s_axi_arvalid,
  input wire logic         s_axi_arready,
  input wire logic         s_axi_rvalid,
  input wire hasd_req_type host_req,
  input wire logic [31:0]  host_wdata,
  input wire hasd_dec_type route,
  input wire logic [31:0]  cfg_addr_out
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // request classes seen at the host port
  wire        hmem = host_req.valid & ~host_req.is_io & ~host_req.from_pci;
  wire        hio  = host_req.valid & host_req.is_io & ~host_req.from_pci;
  wire        pmem = host_req.valid & ~host_req.is_io & host_req.from_pci;
  wire [35:0] a    = host_req.addr;

  // read address handshake on the register port
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  AST_ABOVE_4G: assert property (hmem && a >= `HASD_GB4 |=> route.tgt == HASD_TGT_ABORT)
    else $error("access above 4 GB not terminated");
  AST_ZERO_READ: assert property (hmem && a >= `HASD_GB4 |=> route.zero_read != $past(host_req.write))
    else $error("zero read flag wrong above 4 GB");
  AST_HIGH_PCI: assert property (hmem && a >= `HASD_APIC_LO && a < `HASD_GB4 |=> route.tgt == HASD_TGT_PCI)
    else $error("apic or high bios range not forwarded");
  AST_ABOVE_1G: assert property (hmem && a >= `HASD_TOM_MAX64 && a < `HASD_APIC_LO |=> route.tgt == HASD_TGT_PCI)
    else $error("range above top of memory not forwarded");
  AST_PCI_SMM: assert property (pmem && a >= `HASD_SMM_LO && a < `HASD_SMM_HI |=> route.tgt == HASD_TGT_NONE)
    else $error("pci master reached smm range");
  AST_PCI_SHADOW: assert property (pmem && a >= `HASD_SHD_LO && a < `HASD_SHD_HI |=> route.tgt == HASD_TGT_NONE)
    else $error("pci master claimed in shadow range");
  AST_CFG_PORT: assert property (hio && a[15:0] == `HASD_IO_CFGADDR |=> route.tgt == HASD_TGT_INTERN && !route.cfg_data)
    else $error("config address port not claimed");
  AST_DATA_PORT: assert property (hio && a[15:0] == `HASD_IO_CFGDATA |=> route.tgt == HASD_TGT_INTERN && route.cfg_data)
    else $error("config data port not claimed");
  AST_IO_FWD: assert property (hio && a[15:0] != `HASD_IO_CFGADDR && a[15:0] != `HASD_IO_CFGDATA
    |=> route.tgt == HASD_TGT_PCI)
    else $error("host io cycle not forwarded");
  AST_CFG_LOAD: assert property (hio && host_req.write && a[15:0] == `HASD_IO_CFGADDR
    |=> cfg_addr_out == $past(host_wdata))
    else $error("config address not loaded");
  AST_VALID: assert property (host_req.valid |=> route.valid)
    else $error("route result missing");
  AST_RD_ANSWER: assert property (s_rd_taken |=> s_axi_rvalid)
    else $error("read answer late");
endmodule

bind hasd_top hasd_top_monitor i_mon (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .host_req, .host_wdata, .route, .cfg_addr_out);

//--- test/hasd_host_model.sv
// model of the requesters: host processors and pci masters
// assumes requests launch just after a rising edge of aclk
`timescale 1ns/1ns
module hasd_host_model
  import hasd_pkg::*;
(
  input  wire logic    aclk,
  output hasd_req_type host_req,
  output logic [31:0]  host_wdata
);
  logic [35:0] idle_addr = 36'h5_A5A5_A5A5;

  // bus at rest before the first request
  initial begin
    host_req = '0;
    host_wdata = 32'h0;
  end

  // one request for one cycle, then release with scrambled address and data
  task automatic send(input hasd_req_type r, input logic [31:0] d);
    @(posedge aclk);
    host_req <= r;
    host_wdata <= d;
    @(posedge aclk);
    idle_addr = ~idle_addr;
    host_req <= {5'h00, idle_addr};
    host_wdata <= ~d;
  endtask
endmodule

//--- test/hasd_top_tb.sv
// self-checking bench of the decoder: register access and routing sequences
// assumes the host model drives requests and the checker is bound in
`timescale 1ns/1ns
`include "hasd_consts.svh"
module hasd_top_tb
  import hasd_pkg::*;
;
  localparam logic [3:0] MR = 4'h0, MW = 4'h4, SR = 4'h2, SW = 4'h6, PR = 4'h1, IR = 4'h8, IW = 4'hC, PI = 4'h9;
  logic         aclk = 1'h0, aresetn = 1'h0;
  logic [11:0]  s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0]  s_axi_wdata = 32'h0;
  logic [3:0]   s_axi_wstrb = 4'hF;
  logic         s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic         s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]   s_axi_bresp, s_axi_rresp;
  logic [31:0]  s_axi_rdata, cfg_addr_out, host_rdata, host_wdata;
  hasd_req_type host_req;
  hasd_dec_type route;
  int           mismatches = 0, checks = 0, cyc = 0;

  hasd_top i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .host_req, .host_wdata, .route, .cfg_addr_out, .host_rdata);
  hasd_host_model i_host (.aclk, .host_req, .host_wdata);

  // 100 mhz clock and hang guard
  always #5 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (mismatches == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // register write: address and data offered together, response awaited
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er, input logic [3:0] st = 4'hF);
    logic aw_ok, w_ok;
    aw_ok = 1'h0;
    w_ok = 1'h0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready === 1'h1) begin
        aw_ok = 1'h1;
        s_axi_awvalid <= 1'h0;
      end
      if (!w_ok && s_axi_wready === 1'h1) begin
        w_ok = 1'h1;
        s_axi_wvalid <= 1'h0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    cmp(s_axi_bresp, er);
  endtask

  // register read: data and response taken at the answering edge
  task automatic axi_rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge aclk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    cmp({s_axi_rresp, s_axi_rdata}, {er, ed});
  endtask

  function automatic hasd_dec_type ex(input hasd_tgt_type t, input logic z = 1'h0, input logic c = 1'h0);
    return {1'h1, t, z, c};
  endfunction

  // one request through the host model, route checked one cycle later
  task automatic chk(input logic [3:0] f, input logic [35:0] a, input hasd_dec_type e, input logic [31:0] d = 32'h0);
    i_host.send({1'h1, f, a}, d);
    #1;
    cmp(route, e);
  endtask

  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    // reset values and refused accesses
    axi_rd(`HASD_OFF_TOM, `HASD_TOM_RST, 2'h0);
    for (int i = 4; i <= 16; i += 4) axi_rd(i[11:0], 32'h0, 2'h0);
    axi_rd(12'h018, 32'h0, 2'h2);
    axi_rd(12'h002, 32'h0, 2'h2);
    axi_wr(`HASD_OFF_STATUS, 32'hFFFF_FFFF, 2'h2);
    axi_wr(12'h020, 32'h1, 2'h2);
    // default map with a 16 MB top of memory
    chk(MR, 36'h0_0000_0000, ex(HASD_TGT_DRAM));
    chk(MR, 36'h0_0010_0000, ex(HASD_TGT_DRAM));
    chk(MW, 36'h0_00FF_FFFC, ex(HASD_TGT_DRAM));
    chk(MR, 36'h0_0100_0000, ex(HASD_TGT_PCI));
    chk(MR, 36'h0_FEC0_0000, ex(HASD_TGT_PCI));
    chk(MW, 36'h0_FEC0_FFFC, ex(HASD_TGT_PCI));
    chk(MR, 36'h0_FEC1_0000, ex(HASD_TGT_PCI));
    chk(MR, 36'h0_FFDF_FFFC, ex(HASD_TGT_PCI));
    chk(MR, 36'h0_FFE0_0000, ex(HASD_TGT_PCI));
    chk(MR, 36'h0_FFFF_FFF0, ex(HASD_TGT_PCI));
    chk(MR, 36'h1_0000_0000, ex(HASD_TGT_ABORT, 1'h1));
    cmp(host_rdata, 32'h0);
    chk(MW, 36'hF_FFFF_FFF0, ex(HASD_TGT_ABORT));
    axi_rd(`HASD_OFF_STATUS, 32'h0010_0002, 2'h0);
    chk(MR, 36'h0_000A_0000, ex(HASD_TGT_PCI));
    chk(MW, 36'h0_000B_FFFC, ex(HASD_TGT_PCI));
    // dram hole over 80000h to 9FFFFh
    axi_wr(`HASD_OFF_HOLE, 32'h1, 2'h0);
    chk(MR, 36'h0_0008_0000, ex(HASD_TGT_PCI));
    chk(MW, 36'h0_0009_FFFC, ex(HASD_TGT_PCI));
    chk(MR, 36'h0_0007_FFFC, ex(HASD_TGT_DRAM));
    axi_wr(`HASD_OFF_HOLE, 32'h0, 2'h0);
    chk(MR, 36'h0_0008_0000, ex(HASD_TGT_DRAM));
    // top of memory boundary and its caps
    axi_wr(`HASD_OFF_TOM, 32'h0200_0000, 2'h0);
    axi_rd(`HASD_OFF_TOM, 32'h0200_0000, 2'h0);
    chk(MR, 36'h0_01FF_FFFC, ex(HASD_TGT_DRAM));
    chk(MR, 36'h0_0200_0000, ex(HASD_TGT_PCI));
    axi_wr(`HASD_OFF_TOM, 32'h7FF0_0000, 2'h0);
    chk(MR, 36'h0_0FFF_FFFC, ex(HASD_TGT_DRAM));
    chk(MR, 36'h0_1000_0000, ex(HASD_TGT_PCI));
    axi_wr(`HASD_OFF_TOM, 32'hFFF0_0000, 2'h0);
    chk(MR, 36'h0_3FFF_FFFC, ex(HASD_TGT_DRAM));
    chk(MR, 36'h0_4000_0000, ex(HASD_TGT_PCI));
    chk(PR, 36'h0_0020_0000, ex(HASD_TGT_DRAM));
    chk(PR, 36'h0_4000_0000, ex(HASD_TGT_NONE));
    // smm overlay: enabled alone, then enabled and initialised
    axi_wr(`HASD_OFF_SMM, 32'h1, 2'h0);
    chk(SR, 36'h0_000A_0000, ex(HASD_TGT_PCI));
    axi_wr(`HASD_OFF_SMM, 32'h3, 2'h0);
    chk(SR, 36'h0_000A_0000, ex(HASD_TGT_DRAM));
    chk(SW, 36'h0_000B_FFFC, ex(HASD_TGT_DRAM));
    chk(MR, 36'h0_000A_0000, ex(HASD_TGT_PCI));
    chk(PR, 36'h0_000A_0000, ex(HASD_TGT_NONE));
    // shadow: block 0 read from dram, block 1 written to dram
    axi_wr(`HASD_OFF_SHADOW, 32'h0002_0001, 2'h0);
    axi_rd(`HASD_OFF_SHADOW, 32'h0002_0001, 2'h0);
    chk(MR, 36'h0_000C_0000, ex(HASD_TGT_DRAM));
    chk(MW, 36'h0_000C_0000, ex(HASD_TGT_PCI));
    chk(MR, 36'h0_000C_4000, ex(HASD_TGT_PCI));
    chk(MW, 36'h0_000C_7FFC, ex(HASD_TGT_DRAM));
    chk(MR, 36'h0_000F_C000, ex(HASD_TGT_PCI));
    chk(PR, 36'h0_000C_0000, ex(HASD_TGT_NONE));
    // byte strobe: only the write enables of blocks 0 to 7 change
    axi_wr(`HASD_OFF_SHADOW, 32'hFFFF_FFFF, 2'h0, 4'h4);
    axi_rd(`HASD_OFF_SHADOW, 32'h00FF_0001, 2'h0);
    chk(MW, 36'h0_000D_C000, ex(HASD_TGT_DRAM));
    chk(MR, 36'h0_000D_C000, ex(HASD_TGT_PCI));
    // io space and the two configuration ports
    chk(IW, 36'h0_0000_0CF8, ex(HASD_TGT_INTERN), 32'h8000_1234);
    cmp(cfg_addr_out, 32'h8000_1234);
    chk(IR, 36'h0_0000_0CF8, ex(HASD_TGT_INTERN));
    cmp(host_rdata, 32'h8000_1234);
    chk(MR, 36'h2_0000_0000, ex(HASD_TGT_ABORT, 1'h1));
    cmp(host_rdata, 32'h0);
    chk(IR, 36'h0_0000_0CFC, ex(HASD_TGT_INTERN, 1'h0, 1'h1));
    chk(IW, 36'h0_0000_0080, ex(HASD_TGT_PCI));
    chk(IR, 36'h0_0000_0CFA, ex(HASD_TGT_PCI));
    chk(PI, 36'h0_0000_0CF8, ex(HASD_TGT_NONE));
    // handler saves the config address, uses the port, restores it
    axi_rd(`HASD_OFF_CFGADDR, 32'h8000_1234, 2'h0);
    chk(IW, 36'h0_0000_0CF8, ex(HASD_TGT_INTERN), 32'h8000_0AA0);
    axi_wr(`HASD_OFF_CFGADDR, 32'h8000_1234, 2'h0);
    cmp(cfg_addr_out, 32'h8000_1234);
    report_and_stop();
  end
endmodule
